// *** design/utrc_cfg.svh ***
// Register offsets, field positions and reset values for the transceiver block.
`ifndef UTRC_CFG_SVH
`define UTRC_CFG_SVH
`define UTRC_REGCTL_IDX 8'h73
`define UTRC_XCVR_IDX 8'h74
`define UTRC_REGCTL_ADDR 10'h1cc
`define UTRC_XCVR_ADDR 10'h1d0
`define UTRC_XCVR_PULLUP_BIT 7
`define UTRC_XCVR_FORCE_BIT 0
`define UTRC_REG_ENABLE_BIT 0
`define UTRC_REG_KEEPALIVE_BIT 1
`define UTRC_XCVR_MASK 8'h81
`define UTRC_REGCTL_MASK 8'h03
`define UTRC_RESET_VAL 8'h00
`define UTRC_HTRANS_NONSEQ 2'h2
`endif

// *** design/utrc_pkg.sv ***
// Types shared by the transceiver and regulator control block.
package utrc_pkg;
  typedef enum logic [1:0] {
    UTRC_SUPPLY_NONE,
    UTRC_SUPPLY_MAIN,
    UTRC_SUPPLY_REG33
  } utrc_supply_e;
endpackage : utrc_pkg

// *** design/utrc_ctrl.sv ***
// Transceiver and regulator control registers behind an AHB-Lite slave.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "utrc_cfg.svh"
module utrc_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic usbMode,
  input wire logic port1Bit0,
  input wire logic port1Bit1,
  output logic forceActive,
  output logic dMinusForced,
  output logic dPlusForced,
  output logic pullupConnect,
  output var utrc_pkg::utrc_supply_e pullupSupply,
  output logic regulatorOutputOn,
  output logic regulatorKeepAlive,
  output logic sharedPinGpioOff,
  output logic altDriveAllowed
);

  logic [7:0] xcvr_q;
  logic [7:0] xcvr_d;
  logic [7:0] regCtl_q;
  logic [7:0] regCtl_d;
  logic wrPend_q;
  logic wrPend_d;
  logic [9:0] wrAddr_q;
  logic [9:0] wrAddr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0] sync0_q;
  logic [2:0] sync0_d;
  logic [2:0] sync1_q;
  logic [2:0] sync1_d;
  logic addrPhase;

  // An address phase is taken when the bus is ready and a selected transfer is NONSEQ.
  assign addrPhase = hsel && hready && htrans == `UTRC_HTRANS_NONSEQ;
  // Every access ends in its first data cycle with an OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Bus decode, write capture and register update; a write lands at the end
  // of its data phase, the only cycle in which hwdata is valid.
  always_comb begin
    wrPend_d = addrPhase && hwrite;
    wrAddr_d = addrPhase ? haddr[9:0] : wrAddr_q;
    xcvr_d = xcvr_q;
    regCtl_d = regCtl_q;
    rdata_d = rdata_q;
    if (wrPend_q && wrAddr_q == `UTRC_XCVR_ADDR) begin
      xcvr_d = hwdata[7:0] & `UTRC_XCVR_MASK;
    end
    if (wrPend_q && wrAddr_q == `UTRC_REGCTL_ADDR) begin
      regCtl_d = hwdata[7:0] & `UTRC_REGCTL_MASK;
    end
    // Reads use the next value, so a read right behind a write sees it.
    if (addrPhase && !hwrite) begin
      if (haddr[9:0] == `UTRC_XCVR_ADDR) begin
        rdata_d = {24'h000000, xcvr_d};
      end else if (haddr[9:0] == `UTRC_REGCTL_ADDR) begin
        rdata_d = {24'h000000, regCtl_d};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // Register state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xcvr_q <= `UTRC_RESET_VAL;
      regCtl_q <= `UTRC_RESET_VAL;
      wrPend_q <= 1'b0;
      wrAddr_q <= 10'h000;
      rdata_q <= 32'h00000000;
    end else begin
      xcvr_q <= xcvr_d;
      regCtl_q <= regCtl_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q <= rdata_d;
    end
  end

  // Pin inputs pass two flip-flops before use; only stage two is read.
  always_comb begin
    sync0_d = {usbMode, port1Bit1, port1Bit0};
    sync1_d = sync0_q;
  end

  // Synchroniser stages.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync0_q <= 3'h0;
      sync1_q <= 3'h0;
    end else begin
      sync0_q <= sync0_d;
      sync1_q <= sync1_d;
    end
  end

  // Pin control derived from the two registers and the synchronised pins.
  assign pullupConnect = xcvr_q[`UTRC_XCVR_PULLUP_BIT];
  assign pullupSupply = !pullupConnect ? utrc_pkg::UTRC_SUPPLY_NONE :
    regCtl_q[`UTRC_REG_ENABLE_BIT] ? utrc_pkg::UTRC_SUPPLY_REG33 :
    utrc_pkg::UTRC_SUPPLY_MAIN;
  // Force acts only once the USB-mode level has passed the synchroniser.
  assign forceActive = xcvr_q[`UTRC_XCVR_FORCE_BIT] && sync1_q[2];
  assign dMinusForced = sync1_q[1];
  assign dPlusForced = sync1_q[0];
  assign regulatorOutputOn = regCtl_q[`UTRC_REG_ENABLE_BIT];
  assign sharedPinGpioOff = regCtl_q[`UTRC_REG_ENABLE_BIT];
  // Keep-alive matters only while the full regulator output is off.
  assign regulatorKeepAlive = regCtl_q[`UTRC_REG_KEEPALIVE_BIT] &&
    !regCtl_q[`UTRC_REG_ENABLE_BIT];
  assign altDriveAllowed = regCtl_q[`UTRC_REG_ENABLE_BIT];

  // Checks on reset, pin control and the register path.
  property p_pullup_reset;
    @(posedge clk) $rose(rst_b) |-> !pullupConnect;
  endproperty
  a_pullup_reset: assert property (p_pullup_reset)
    else $error("pull-up connected straight after reset");

  property p_supply;
    @(posedge clk) disable iff (!rst_b) pullupConnect && regulatorOutputOn
      |-> pullupSupply == utrc_pkg::UTRC_SUPPLY_REG33;
  endproperty
  a_supply: assert property (p_supply)
    else $error("pull-up not on the regulated rail");

  property p_supply_main;
    @(posedge clk) disable iff (!rst_b) pullupConnect && !regulatorOutputOn
      |-> pullupSupply == utrc_pkg::UTRC_SUPPLY_MAIN;
  endproperty
  a_supply_main: assert property (p_supply_main)
    else $error("pull-up not on the main supply");

  property p_supply_none;
    @(posedge clk) disable iff (!rst_b) !pullupConnect
      |-> pullupSupply == utrc_pkg::UTRC_SUPPLY_NONE;
  endproperty
  a_supply_none: assert property (p_supply_none)
    else $error("pull-up supplied while disconnected");

  property p_force;
    @(posedge clk) disable iff (!rst_b) forceActive
      |-> dMinusForced == $past(port1Bit1, 2)
      && dPlusForced == $past(port1Bit0, 2);
  endproperty
  a_force: assert property (p_force)
    else $error("forced pins do not follow port 1");

  property p_force_usb;
    @(posedge clk) disable iff (!rst_b) forceActive
      |-> xcvr_q[`UTRC_XCVR_FORCE_BIT] && $past(usbMode, 2);
  endproperty
  a_force_usb: assert property (p_force_usb)
    else $error("force active outside USB mode");

  property p_keep;
    @(posedge clk) disable iff (!rst_b) regulatorKeepAlive |-> !regulatorOutputOn;
  endproperty
  a_keep: assert property (p_keep)
    else $error("keep-alive with regulator on");

  property p_write_xcvr;
    @(posedge clk) disable iff (!rst_b)
      addrPhase && hwrite && haddr[9:0] == `UTRC_XCVR_ADDR ##1 1'b1
      |=> xcvr_q == ($past(hwdata[7:0]) & `UTRC_XCVR_MASK);
  endproperty
  a_write_xcvr: assert property (p_write_xcvr)
    else $error("transceiver write lost");

  property p_write_reg;
    @(posedge clk) disable iff (!rst_b)
      addrPhase && hwrite && haddr[9:0] == `UTRC_REGCTL_ADDR ##1 1'b1
      |=> regCtl_q == ($past(hwdata[7:0]) & `UTRC_REGCTL_MASK);
  endproperty
  a_write_reg: assert property (p_write_reg)
    else $error("regulator write lost");

  property p_read_xcvr;
    @(posedge clk) disable iff (!rst_b)
      addrPhase && !hwrite && haddr[9:0] == `UTRC_XCVR_ADDR
      |=> hrdata == {24'h000000, xcvr_q};
  endproperty
  a_read_xcvr: assert property (p_read_xcvr)
    else $error("transceiver read data wrong");

  property p_gpio_off;
    @(posedge clk) disable iff (!rst_b) sharedPinGpioOff == regulatorOutputOn;
  endproperty
  a_gpio_off: assert property (p_gpio_off)
    else $error("shared pin not released");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
      xcvr_q[6:1] == 6'h00 && regCtl_q[7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  property p_alt;
    @(posedge clk) disable iff (!rst_b) altDriveAllowed |-> regCtl_q[0];
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate drive without regulator");

  // Main scenarios that the bench should reach.
  c_force: cover property (@(posedge clk) forceActive);
  c_reg33: cover property (@(posedge clk)
    pullupSupply == utrc_pkg::UTRC_SUPPLY_REG33);
  c_main: cover property (@(posedge clk)
    pullupSupply == utrc_pkg::UTRC_SUPPLY_MAIN);
  c_keep: cover property (@(posedge clk) regulatorKeepAlive);
  c_write: cover property (@(posedge clk) wrPend_q);

endmodule : utrc_ctrl
`default_nettype wire

// *** verif/utrc_host_model.sv ***
// Host-side model that senses device attach on the D- line.
`timescale 1ns/1ps
`default_nettype none
module utrc_host_model (
  input wire logic pullupConnect,
  input wire utrc_pkg::utrc_supply_e pullupSupply,
  output logic devAttached
);
  // A low-speed attach needs the D- pull-up tied to a supply.
  assign devAttached = pullupConnect &&
    pullupSupply != utrc_pkg::UTRC_SUPPLY_NONE;
endmodule : utrc_host_model
`default_nettype wire

// *** verif/test_utrc_ctrl.sv ***
// Self-checking bench for the transceiver and regulator control block.
`timescale 1ns/1ps
`default_nettype none
`include "utrc_cfg.svh"
module test_utrc_ctrl;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, stat;
  logic [1:0] htrans = 2'h0;
  logic usbMode = 1'b0, port1Bit0 = 1'b0, port1Bit1 = 1'b0;
  logic hreadyout, hresp, fa, dm, dp, pc, ro, ka, go, ad, att;
  logic [7:0] x, r;
  utrc_pkg::utrc_supply_e ps;
  int n_fail = 0, check_count = 0, cycles = 0;
  assign stat = {22'h0, fa, dm, dp, pc, ps, ro, ka, go, ad};
  utrc_ctrl uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .usbMode(usbMode), .port1Bit0(port1Bit0), .port1Bit1(port1Bit1),
    .forceActive(fa), .dMinusForced(dm), .dPlusForced(dp),
    .pullupConnect(pc), .pullupSupply(ps), .regulatorOutputOn(ro),
    .regulatorKeepAlive(ka), .sharedPinGpioOff(go), .altDriveAllowed(ad));
  utrc_host_model host (.pullupConnect(pc), .pullupSupply(ps),
    .devAttached(att));
  // Free-running clock.
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [31:0] a, input logic w, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `UTRC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus
  task automatic finish_test();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // Main sequence of register accesses and output checks.
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(`UTRC_REGCTL_ADDR, 1'b0, 32'h0);
    chk(rv, 32'h0);
    bus(`UTRC_XCVR_ADDR, 1'b0, 32'h0);
    chk(rv, 32'h0);
    for (int i = 0; i < 32; i++) begin
      x = {i[1], 6'h3f, i[0]};
      r = {6'h3f, i[3:2]};
      usbMode <= i[4];
      port1Bit0 <= i[0];
      port1Bit1 <= i[1] ^ i[4];
      bus(`UTRC_REGCTL_ADDR, 1'b1, {24'hffffff, r});
      bus(`UTRC_XCVR_ADDR, 1'b1, {24'hffffff, x});
      repeat (3) @(posedge clk);
      chk(stat, {22'h0, x[0] & i[4], i[1] ^ i[4], i[0], x[7],
        x[7] ? (r[0] ? 2'h2 : 2'h1) : 2'h0, r[0], r[1] & !r[0], r[0],
        r[0]});
      chk(att, x[7]);
      bus(`UTRC_XCVR_ADDR, 1'b0, 32'h0);
      chk(rv, {24'h0, x & `UTRC_XCVR_MASK});
      bus(`UTRC_REGCTL_ADDR, 1'b0, 32'h0);
      chk(rv, {24'h0, r & `UTRC_REGCTL_MASK});
    end
    bus(32'h1d4, 1'b1, 32'hff);
    chk({hreadyout, hresp}, 2'h2);
    bus(32'h1d4, 1'b0, 32'h0);
    chk(rv, 32'h0);
    bus(`UTRC_REGCTL_ADDR, 1'b1, 32'h2);
    bus(`UTRC_REGCTL_ADDR, 1'b0, 32'h0);
    chk(rv, 32'h2);
    chk({ro, ka}, 2'h1);
    rst_b <= 1'b0;
    @(posedge clk);
    chk({fa, pc, ro, ka, go, ad, ps}, 8'h00);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(`UTRC_XCVR_ADDR, 1'b0, 32'h0);
    chk(rv, 32'h0);
    bus(`UTRC_REGCTL_ADDR, 1'b0, 32'h0);
    chk(rv, 32'h0);
    finish_test();
  end
endmodule : test_utrc_ctrl
`default_nettype wire
